// ==== logic/scc_pkg.sv ====
// package: register map, field layout and shared types of the sc unit
package scc_pkg;
  localparam logic [3:0] ADDR_CTL  = 4'h0; // control, or count in counter mode
  localparam logic [3:0] ADDR_MASK = 4'h1; // mask, or period in counter mode
  localparam logic [3:0] ADDR_AUX  = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam logic [3:0] ADDR_MDLO = 4'h4;
  localparam logic [3:0] ADDR_MDHI = 4'h5;
  localparam logic [3:0] ADDR_CFG  = 4'h6;
  localparam logic [3:0] ADDR_STMD = 4'h7;
  localparam int AUX_FLUSH_A = 0;
  localparam int AUX_THR_A   = 2;
  localparam int AUX_INT     = 4;
  localparam int AUX_RUN     = 5;
  localparam logic [7:0] AUX_WMASK = 8'h3f;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] THR_HALF   = 3'h2;
  localparam logic [2:0] THR_ONE    = 3'h1;
  typedef enum logic [1:0] {
    ROUTE_CTL = 2'h0, ROUTE_PAR = 2'h1, ROUTE_CNT = 2'h2, ROUTE_RSV = 2'h3
  } scc_route_t;
  typedef enum logic [1:0] {
    MD_DIRECT = 2'h0, MD_SYNC = 2'h1, MD_RSV = 2'h2, MD_PULSE = 2'h3
  } scc_bitmode_t;
  typedef struct packed {
    logic       ld_used;
    logic       en_used;
    logic       tc_alt;
    logic       sync_mode;
    scc_route_t route;
    logic       reset_scope_select;
  } scc_cfg_t;
  localparam scc_cfg_t CFG_RST = 7'h00;
  typedef struct packed {
    logic       dir_out;
    logic [2:0] level;
  } scc_fifo_t;
endpackage

// ==== logic/scc_unit.sv ====
// status and control unit: control bits, counter, sync, aux control
`timescale 1ns/1ps
module scc_unit #(
  parameter int CTL_W  = 8,
  parameter int CNT_W  = 7,
  parameter int SYNC_W = 4,
  parameter int N_FIFO = 2
) (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic                                i_bus_wr,
  input  wire logic                                i_bus_rd,
  input  wire logic [3:0]                          i_bus_addr,
  input  wire logic [7:0]                          i_bus_wdata,
  output logic      [7:0]                          o_bus_rdata,
  input  wire logic                                i_routed_reset,
  input  wire logic                                i_routed_enable,
  input  wire logic                                i_routed_period_load,
  input  wire logic [7:0]                          i_status_in,
  input  wire logic [7:0]                          i_datapath_parallel_out,
  output logic      [7:0]                          o_datapath_parallel_in,
  input  wire logic [SYNC_W-1:0]                   i_synchronizer_inputs,
  output logic      [SYNC_W-1:0]                   o_shared_io_outputs,
  output logic      [SYNC_W-1:0]                   o_shared_io_oe_n,
  output logic      [7:0]                          o_fabric_output_bus,
  output logic                                     o_interrupt,
  input  wire scc_pkg::scc_fifo_t [N_FIFO-1:0]     i_fifo,
  output logic      [N_FIFO-1:0]                   o_fifo_flush,
  output logic      [N_FIFO-1:0]                   o_fifo_bus_status
);
  logic [CTL_W-1:0]  ctl_ff, nxt_ctl, sync_ff, nxt_sync, fab_ctl;
  logic [7:0]        mask_ff, mdlo_ff, mdhi_ff, stmd_ff, stky_ff, aux_ff;
  logic [7:0]        fab_ff, rd_ff, par_ff, stat_val, nxt_fab;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt, period;
  logic [SYNC_W-1:0] s1_ff, s2_ff, oe_n_ff;
  logic [N_FIFO-1:0] fst_ff;
  logic              int_ff, wr_ctl, is_cnt, sync_on, en_used, ld_used;
  logic              run, en_act, ld_act, tc_now, tc_bit;
  scc_pkg::scc_cfg_t cfg_ff;

  // mode of one control bit from the high and low mode registers
  function automatic scc_pkg::scc_bitmode_t bit_mode(
    input logic [7:0] hi, input logic [7:0] lo, input int i);
    return scc_pkg::scc_bitmode_t'({hi[i], lo[i]});
  endfunction

  // shared decode terms
  assign wr_ctl  = i_bus_wr && (i_bus_addr == scc_pkg::ADDR_CTL);
  assign is_cnt  = (cfg_ff.route == scc_pkg::ROUTE_CNT);
  assign sync_on = cfg_ff.sync_mode;
  assign en_used = cfg_ff.en_used & ~sync_on;
  assign ld_used = cfg_ff.ld_used & ~sync_on;
  assign period  = mask_ff[CNT_W-1:0];
  assign run     = is_cnt & aux_ff[scc_pkg::AUX_RUN];
  assign en_act  = run & (~en_used | i_routed_enable);
  assign tc_now  = (cnt_ff == '0);
  // load gated by enable unless alternate mode
  assign ld_act  = ld_used & i_routed_period_load &
                   (cfg_ff.tc_alt ? is_cnt : en_act);

  // counter next value: load, then count with reload, then bus write
  always_comb begin
    nxt_cnt = cnt_ff;
    if (ld_act) begin
      nxt_cnt = period;
    end else if (en_act) begin
      nxt_cnt = tc_now ? period : cnt_ff - 1'b1;
    end else if (wr_ctl && is_cnt) begin
      nxt_cnt = i_bus_wdata[CNT_W-1:0];
    end
  end

  // per-bit control next state for direct, sync and pulse modes
  always_comb begin
    for (int i = 0; i < CTL_W; i++) begin
      nxt_ctl[i]  = ctl_ff[i];
      nxt_sync[i] = ctl_ff[i];
      if (bit_mode(mdhi_ff, mdlo_ff, i) == scc_pkg::MD_PULSE) begin
        nxt_sync[i] = ctl_ff[i] & ~sync_ff[i];
        if (sync_ff[i]) begin
          nxt_ctl[i] = 1'b0;
        end
      end
      if (i_routed_reset) begin
        nxt_sync[i] = 1'b0;
        if (cfg_ff.reset_scope_select) begin
          nxt_ctl[i] = 1'b0;
        end
      end
      if (wr_ctl && !is_cnt) begin
        if (bit_mode(mdhi_ff, mdlo_ff, i) == scc_pkg::MD_PULSE) begin
          nxt_ctl[i] = nxt_ctl[i] | i_bus_wdata[i];
        end else begin
          nxt_ctl[i] = i_bus_wdata[i];
        end
      end
      fab_ctl[i] = (bit_mode(mdhi_ff, mdlo_ff, i) == scc_pkg::MD_DIRECT) ?
                   nxt_ctl[i] : nxt_sync[i];
    end
  end

  // fabric output source chosen by the route select bits
  always_comb begin
    tc_bit = cfg_ff.tc_alt ? (nxt_cnt == '0) : tc_now;
    case (cfg_ff.route)
      scc_pkg::ROUTE_PAR: nxt_fab = i_datapath_parallel_out;
      scc_pkg::ROUTE_CNT: nxt_fab = {tc_bit, nxt_cnt};
      default:            nxt_fab = fab_ctl;
    endcase
  end

  // control bits, resampled outputs and fabric output
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_ff  <= '0;
      sync_ff <= '0;
      fab_ff  <= '0;
    end else begin
      ctl_ff  <= nxt_ctl;
      sync_ff <= nxt_sync;
      fab_ff  <= nxt_fab;
    end
  end

  // down counter
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // configuration, mode, mask/period and aux registers
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mask_ff <= scc_pkg::REG_RST;
      mdlo_ff <= scc_pkg::REG_RST;
      mdhi_ff <= scc_pkg::REG_RST;
      stmd_ff <= scc_pkg::REG_RST;
      aux_ff  <= scc_pkg::REG_RST;
      cfg_ff  <= scc_pkg::CFG_RST;
    end else if (i_bus_wr) begin
      case (i_bus_addr)
        scc_pkg::ADDR_MASK: mask_ff <= i_bus_wdata;
        scc_pkg::ADDR_MDLO: mdlo_ff <= i_bus_wdata;
        scc_pkg::ADDR_MDHI: mdhi_ff <= i_bus_wdata;
        scc_pkg::ADDR_STMD: stmd_ff <= i_bus_wdata;
        scc_pkg::ADDR_AUX:  aux_ff  <= i_bus_wdata & scc_pkg::AUX_WMASK;
        scc_pkg::ADDR_CFG:  cfg_ff  <= scc_pkg::scc_cfg_t'(i_bus_wdata[6:0]);
        default: ;
      endcase
    end
  end

  // status value: sticky bits or live inputs
  assign stat_val = (stmd_ff & stky_ff) | (~stmd_ff & i_status_in);

  // sticky capture; a read clears only bits that were set, new sets win
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stky_ff <= '0;
    end else if (sync_on) begin
      stky_ff <= '0;
    end else if (i_bus_rd && i_bus_addr == scc_pkg::ADDR_STAT) begin
      stky_ff <= (stky_ff & ~stat_val) | i_status_in;
    end else begin
      stky_ff <= stky_ff | i_status_in;
    end
  end

  // interrupt from masked low status bits, gated by aux bit 4
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= aux_ff[scc_pkg::AUX_INT] & ~is_cnt & ~sync_on &
                (|(stat_val[6:0] & mask_ff[6:0]));
    end
  end

  // double synchronizer and shared io direction
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      oe_n_ff <= '1;
      par_ff  <= '0;
    end else begin
      s1_ff   <= i_synchronizer_inputs;
      s2_ff   <= s1_ff;
      oe_n_ff <= {SYNC_W{~sync_on}};
      par_ff  <= i_status_in;
    end
  end

  // fifo bus status against the threshold bits
  for (genvar f = 0; f < N_FIFO; f++) begin : g_fifo
    logic [2:0] avail;
    assign avail = i_fifo[f].dir_out ? i_fifo[f].level :
                   scc_pkg::FIFO_DEPTH - i_fifo[f].level;
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        fst_ff[f] <= 1'b0;
      end else begin
        fst_ff[f] <= ~aux_ff[scc_pkg::AUX_FLUSH_A + f] &
                     (avail >= (aux_ff[scc_pkg::AUX_THR_A + f] ?
                      scc_pkg::THR_HALF : scc_pkg::THR_ONE));
      end
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_ff <= '0;
    end else if (i_bus_rd) begin
      case (i_bus_addr)
        scc_pkg::ADDR_CTL:  rd_ff <= is_cnt ? {1'b0, cnt_ff} : ctl_ff;
        scc_pkg::ADDR_MASK: rd_ff <= mask_ff;
        scc_pkg::ADDR_AUX:  rd_ff <= aux_ff;
        scc_pkg::ADDR_STAT: rd_ff <= sync_on ? {4'h0, s2_ff} : stat_val;
        scc_pkg::ADDR_MDLO: rd_ff <= mdlo_ff;
        scc_pkg::ADDR_MDHI: rd_ff <= mdhi_ff;
        scc_pkg::ADDR_STMD: rd_ff <= stmd_ff;
        scc_pkg::ADDR_CFG:  rd_ff <= {1'b0, cfg_ff};
        default:            rd_ff <= '0;
      endcase
    end
  end

  // outputs straight from flops
  assign o_bus_rdata            = rd_ff;
  assign o_fabric_output_bus    = fab_ff;
  assign o_datapath_parallel_in = par_ff;
  assign o_shared_io_outputs    = s2_ff;
  assign o_shared_io_oe_n       = oe_n_ff;
  assign o_interrupt            = int_ff;
  assign o_fifo_flush = {aux_ff[scc_pkg::AUX_FLUSH_A + 1],
                         aux_ff[scc_pkg::AUX_FLUSH_A]};
  assign o_fifo_bus_status      = fst_ff;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  logic pulse0;
  assign pulse0 = bit_mode(mdhi_ff, mdlo_ff, 0) == scc_pkg::MD_PULSE;

  sequence s_wr1;
    wr_ctl && !is_cnt && i_bus_wdata[0] && !ctl_ff[0] && pulse0;
  endsequence
  sequence s_arm;
    pulse0 && !i_routed_reset;
  endsequence

  property p_pulse_start;
    s_wr1 ##1 s_arm |=> sync_ff[0] && ctl_ff[0];
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("pulse did not start");
  property p_pulse_one;
    pulse0 && sync_ff[0] |=> !sync_ff[0];
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("pulse longer than one cycle");
  property p_read_back;
    s_arm and (ctl_ff[0] && !sync_ff[0]) |=> ctl_ff[0];
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("pulse bit cleared early");
  property p_scope0;
    i_routed_reset && !cfg_ff.reset_scope_select && !wr_ctl &&
      mdhi_ff == '0 |=> sync_ff == '0 && ctl_ff == $past(ctl_ff);
  endproperty
  a_scope0: assert property (p_scope0)
    else $error("scope 0 reset touched control");
  property p_scope1;
    i_routed_reset && cfg_ff.reset_scope_select && !wr_ctl
      |=> ctl_ff == '0 && sync_ff == '0;
  endproperty
  a_scope1: assert property (p_scope1)
    else $error("scope 1 reset missed control");
  property p_reload;
    en_act && !ld_act && tc_now |=> cnt_ff == $past(period);
  endproperty
  a_reload: assert property (p_reload)
    else $error("no reload at terminal count");
  property p_load;
    ld_act[*2] |=> cnt_ff == $past(period);
  endproperty
  a_load: assert property (p_load)
    else $error("routed load not applied");
  property p_sync2;
    1'b1 |-> ##2 s2_ff == $past(i_synchronizer_inputs, 2);
  endproperty
  a_sync2: assert property (p_sync2)
    else $error("synchronizer not two stages");
  property p_aux_hi;
    i_bus_wr && i_bus_addr == scc_pkg::ADDR_AUX |=> aux_ff[7:6] == 2'h0;
  endproperty
  a_aux_hi: assert property (p_aux_hi)
    else $error("aux high bits not zero");
  property p_run_gate;
    !aux_ff[scc_pkg::AUX_RUN] && !ld_act |=> cnt_ff == $past(cnt_ff) ||
      $past(wr_ctl);
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("counter moved without run");
endmodule

// ==== verif/scc_fifo_model.sv ====
// fifo model: fill state of the two external fifos seen by the unit
`timescale 1ns/1ps
module scc_fifo_model (
  input  wire logic [1:0]          i_dir_out,
  input  wire logic [2:0]          i_fill_a,
  input  wire logic [2:0]          i_fill_b,
  input  wire logic [1:0]          i_flush,
  output scc_pkg::scc_fifo_t [1:0] o_fifo
);
  // a flushed fifo reads empty while flush is held, then shows its fill input again
  always_comb begin
    o_fifo[0].dir_out = i_dir_out[0];
    o_fifo[1].dir_out = i_dir_out[1];
    o_fifo[0].level   = i_flush[0] ? 3'h0 : i_fill_a;
    o_fifo[1].level   = i_flush[1] ? 3'h0 : i_fill_b;
  end
endmodule

// ==== verif/tb.sv ====
// testbench: directed scenarios for the status and control unit
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module tb;
  logic                      i_sys_clk = 1'b0;
  logic                      i_sys_rst = 1'b1;
  logic                      i_bus_wr = 1'b0;
  logic                      i_bus_rd = 1'b0;
  logic [3:0]                i_bus_addr = 4'h0;
  logic [7:0]                i_bus_wdata = 8'h00;
  logic [7:0]                o_bus_rdata;
  logic                      i_routed_reset = 1'b0;
  logic                      i_routed_enable = 1'b0;
  logic                      i_routed_period_load = 1'b0;
  logic [7:0]                i_status_in = 8'h00;
  logic [7:0]                i_datapath_parallel_out = 8'h00;
  logic [7:0]                o_datapath_parallel_in;
  logic [3:0]                i_synchronizer_inputs = 4'h0;
  logic [3:0]                o_shared_io_outputs;
  logic [3:0]                o_shared_io_oe_n;
  logic [7:0]                o_fabric_output_bus;
  logic                      o_interrupt;
  scc_pkg::scc_fifo_t [1:0]  fifo_w;
  logic [1:0]                o_fifo_flush;
  logic [1:0]                o_fifo_bus_status;
  logic [1:0]                dir_out = 2'b01;
  logic [2:0]                fill_a = 3'h1;
  logic [2:0]                fill_b = 3'h3;
  logic [7:0]                rd_q;
  logic [6:0]                cnt_q;
  int                        num_errors = 0;
  int                        n_checks = 0;

  // clock at 100 mhz
  always #5 i_sys_clk = ~i_sys_clk;

  scc_unit i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .i_routed_reset(i_routed_reset), .i_routed_enable(i_routed_enable),
    .i_routed_period_load(i_routed_period_load), .i_status_in(i_status_in),
    .i_datapath_parallel_out(i_datapath_parallel_out),
    .o_datapath_parallel_in(o_datapath_parallel_in),
    .i_synchronizer_inputs(i_synchronizer_inputs),
    .o_shared_io_outputs(o_shared_io_outputs),
    .o_shared_io_oe_n(o_shared_io_oe_n),
    .o_fabric_output_bus(o_fabric_output_bus), .o_interrupt(o_interrupt),
    .i_fifo(fifo_w), .o_fifo_flush(o_fifo_flush),
    .o_fifo_bus_status(o_fifo_bus_status));

  scc_fifo_model i_fifo_model (.i_dir_out(dir_out), .i_fill_a(fill_a),
    .i_fill_b(fill_b), .i_flush(o_fifo_flush), .o_fifo(fifo_w));

  // one bus cycle; called 1 ns after an edge, returns 1 ns after the next
  task automatic bus_op(input logic w, input logic r, input logic [3:0] a,
                        input logic [7:0] d);
    i_bus_wr = w;
    i_bus_rd = r;
    i_bus_addr = a;
    i_bus_wdata = d;
    @(posedge i_sys_clk);
    #1;
    rd_q = o_bus_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) bus_op(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_op(1'b1, 1'b0, a, d);
    idle(1);
  endtask
  task automatic rd(input logic [3:0] a);
    bus_op(1'b0, 1'b1, a, 8'h00);
    idle(1);
  endtask
  task automatic do_reset();
    i_sys_rst = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_sys_rst = 1'b0;
  endtask

  // aux register: reset value, unused top bits, flush outputs
  task automatic t_aux();
    do_reset();
    rd(scc_pkg::ADDR_AUX);
    `CHK(rd_q, 8'h00)
    wr(scc_pkg::ADDR_AUX, 8'hff);
    rd(scc_pkg::ADDR_AUX);
    `CHK(rd_q, 8'h3f)
    `CHK(o_fifo_flush, 2'b11)
  endtask

  // pulse mode on bit 0, then a second pulse after it reads 0
  task automatic t_pulse();
    do_reset();
    wr(scc_pkg::ADDR_MDLO, 8'h01);
    wr(scc_pkg::ADDR_MDHI, 8'h01);
    bus_op(1'b1, 1'b0, scc_pkg::ADDR_CTL, 8'h01);
    bus_op(1'b0, 1'b1, scc_pkg::ADDR_CTL, 8'h00);
    `CHK(rd_q[0], 1'b1)
    `CHK(o_fabric_output_bus[0], 1'b1)
    idle(1);
    `CHK(o_fabric_output_bus[0], 1'b0)
    rd(scc_pkg::ADDR_CTL);
    `CHK(rd_q[0], 1'b0)
    wr(scc_pkg::ADDR_CTL, 8'h01);
    `CHK(o_fabric_output_bus[0], 1'b1)
  endtask

  // routed reset with both reset scopes, bit 0 in sync mode
  task automatic t_rreset(input logic scope);
    do_reset();
    wr(scc_pkg::ADDR_CFG, {7'h00, scope});
    wr(scc_pkg::ADDR_MDLO, 8'h01);
    wr(scc_pkg::ADDR_CTL, 8'h01);
    idle(2);
    `CHK(o_fabric_output_bus[0], 1'b1)
    i_routed_reset = 1'b1;
    idle(1);
    i_routed_reset = 1'b0;
    `CHK(o_fabric_output_bus[0], 1'b0)
    rd(scc_pkg::ADDR_CTL);
    `CHK(rd_q[0], ~scope)
  endtask

  // parallel output route and the always live parallel input
  task automatic t_par();
    do_reset();
    i_datapath_parallel_out = 8'h5a;
    i_status_in = 8'h3c;
    wr(scc_pkg::ADDR_CFG, 8'h02);
    idle(1);
    `CHK(o_fabric_output_bus, 8'h5a)
    `CHK(o_datapath_parallel_in, 8'h3c)
  endtask

  // counter: reload, load level, enables, alternate mode, period 0
  task automatic t_cnt();
    do_reset();
    wr(scc_pkg::ADDR_CFG, 8'h44);
    wr(scc_pkg::ADDR_MASK, 8'h03);
    wr(scc_pkg::ADDR_CTL, 8'h03);
    wr(scc_pkg::ADDR_AUX, 8'h20);
    for (int k = 0; k < 10 && o_fabric_output_bus[6:0] !== 7'h00; k++)
      idle(1);
    idle(1);
    `CHK(o_fabric_output_bus[6:0], 7'h03)
    `CHK(o_fabric_output_bus[7], 1'b1)
    i_routed_period_load = 1'b1;
    idle(3);
    `CHK(o_fabric_output_bus[6:0], 7'h03)
    i_routed_period_load = 1'b0;
    wr(scc_pkg::ADDR_CFG, 8'h64);
    cnt_q = o_fabric_output_bus[6:0];
    idle(3);
    `CHK(o_fabric_output_bus[6:0], cnt_q)
    wr(scc_pkg::ADDR_MASK, 8'h05);
    i_routed_period_load = 1'b1;
    idle(3);
    `CHK(o_fabric_output_bus[6:0], cnt_q)
    wr(scc_pkg::ADDR_CFG, 8'h74);
    idle(1);
    `CHK(o_fabric_output_bus[6:0], 7'h05)
    i_routed_period_load = 1'b0;
    wr(scc_pkg::ADDR_CFG, 8'h04);
    wr(scc_pkg::ADDR_AUX, 8'h00);
    cnt_q = o_fabric_output_bus[6:0];
    idle(3);
    `CHK(o_fabric_output_bus[6:0], cnt_q)
    wr(scc_pkg::ADDR_MASK, 8'h00);
    wr(scc_pkg::ADDR_AUX, 8'h20);
    idle(8);
    `CHK(o_fabric_output_bus[7], 1'b1)
    idle(3);
    `CHK(o_fabric_output_bus[7], 1'b1)
  endtask

  // double synchronizer drives the shared pins; status reads the sync value
  task automatic t_sync();
    do_reset();
    i_status_in = 8'h01;
    wr(scc_pkg::ADDR_STMD, 8'h01);
    i_status_in = 8'h00;
    wr(scc_pkg::ADDR_CFG, 8'h08);
    i_synchronizer_inputs = 4'ha;
    idle(2);
    `CHK(o_shared_io_outputs, 4'ha)
    `CHK(o_shared_io_oe_n, 4'h0)
    rd(scc_pkg::ADDR_STAT);
    `CHK(rd_q, 8'h0a)
    wr(scc_pkg::ADDR_CFG, 8'h00);
    rd(scc_pkg::ADDR_STAT);
    `CHK(rd_q, 8'h00)
  endtask

  // fifo bus status against both thresholds and flush
  task automatic t_fifo();
    do_reset();
    idle(2);
    `CHK(o_fifo_bus_status, 2'b11)
    wr(scc_pkg::ADDR_AUX, 8'h0c);
    idle(1);
    `CHK(o_fifo_bus_status, 2'b00)
    fill_a = 3'h2;
    fill_b = 3'h2;
    idle(2);
    `CHK(o_fifo_bus_status, 2'b11)
    wr(scc_pkg::ADDR_AUX, 8'h0f);
    idle(1);
    `CHK(o_fifo_bus_status, 2'b00)
    wr(scc_pkg::ADDR_AUX, 8'h0c);
    idle(1);
    `CHK(o_fifo_bus_status, 2'b11)
  endtask

  // interrupt gate over masked status
  task automatic t_int();
    do_reset();
    i_status_in = 8'h01;
    wr(scc_pkg::ADDR_MASK, 8'h01);
    wr(scc_pkg::ADDR_AUX, 8'h10);
    idle(1);
    `CHK(o_interrupt, 1'b1)
    wr(scc_pkg::ADDR_AUX, 8'h00);
    idle(1);
    `CHK(o_interrupt, 1'b0)
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #100us;
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge i_sys_clk);
    #1;
    `CHK(o_shared_io_oe_n, 4'hf)
    t_aux();
    t_pulse();
    t_rreset(1'b0);
    t_rreset(1'b1);
    t_par();
    t_cnt();
    t_sync();
    t_fifo();
    t_int();
    wrap_up();
  end
endmodule
